// ### design/eau_core.sv
// file: effective address unit top
`timescale 1ns/1ns

// ==========================================
// Behaviour
// - disp mode: register plus sign-extended displacement
// - short displacement only for scaled 1..3
// - index: zero-extend, scale by size, add disp
// - post-increment: old address, register plus step
// - pre-decrement: register minus step is address
// - pre-increment: register plus step is address
// - post-decrement: old address, register minus step
// - step is 1, 2 or 4 by size
// - write data is updated register value
// - second address uses updated register
// - 8-bit absolute: upper 24 from base
// - 16-bit absolute sign-extended
// - 32-bit absolute used unmodified except in middle mode
// - 24-bit program address: upper byte zero
// - immediates zero-extended to operand size
// - extract bit number, field, trap vector
// - pc relative: sign-extended disp plus pc
// - pc base is next instruction address
// - advanced mode branch target upper byte zero
// - middle mode data addresses sign-extend bit 15, except 24-bit absolute
// - advanced register-indirect branch upper byte zero
module eau_core
	import eau_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// request from decoder
	input  wire logic        req_valid,
	input  wire logic [3:0]  ea_mode,
	input  wire logic [1:0]  op_size,
	input  wire logic [1:0]  cpu_mode,
	input  wire logic [2:0]  reg_sel,
	input  wire logic [31:0] address_register_32,
	input  wire logic [31:0] index_reg,
	input  wire logic [31:0] disp,
	input  wire logic        disp_long,
	input  wire logic [1:0]  disp_short,
	input  wire logic [31:0] next_pc,
	input  wire logic [15:0] opcode,
	input  wire logic [1:0]  impl_kind,
	input  wire logic        second_ea,
	input  wire logic [31:0] short_address_base,
	// results
	output logic             ea_valid,
	output logic [31:0]      ea_addr,
	output logic [31:0]      imm_value,
	output logic             wb_en,
	output logic [2:0]       wb_reg,
	output logic [31:0]      wb_value,
	output logic [31:0]      reg_wdata,
	output logic             ea_error
);

	// ==========================================
	// reset synchroniser
	logic rst_s1_r;
	logic rst_s2_r;

	// release reset through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// ==========================================
	// helper functions
	function automatic logic [31:0] step_of(input logic [1:0] sz);
		case (sz)
			EAU_SZ_BYTE: step_of = EAU_STEP_BYTE;
			EAU_SZ_WORD: step_of = EAU_STEP_WORD;
			default:     step_of = EAU_STEP_LONG;
		endcase
	endfunction

	function automatic logic [1:0] shift_of(input logic [1:0] sz);
		case (sz)
			EAU_SZ_BYTE: shift_of = 2'h0;
			EAU_SZ_WORD: shift_of = 2'(EAU_SHIFT_WORD);
			default:     shift_of = 2'(EAU_SHIFT_LONG);
		endcase
	endfunction

	// sign-extend a 16-bit value to 32 bits
	function automatic logic [31:0] sx16(input logic [31:0] v);
		sx16 = {{16{v[15]}}, v[15:0]};
	endfunction

	// ==========================================
	// forwarding of the last write-back for a second address
	logic [31:0] fwd_val_r, fwd_val_nxt, base;
	logic [2:0]  fwd_reg_r, fwd_reg_nxt;
	logic        fwd_ok_r, fwd_ok_nxt;

	// pick the updated register when the same one feeds a second address
	always_comb begin
		base = address_register_32;
		if (second_ea && fwd_ok_r && fwd_reg_r == reg_sel) begin
			base = fwd_val_r;
		end
	end

	// ==========================================
	// extension units
	logic [31:0] disp_x, idx_scaled, imm_x, pc_disp;

	// displacement: sign-extend the short form
	eau_ext u_disp (
		.src      (disp),
		.size     (disp_long ? EAU_SZ_LONG : EAU_SZ_WORD),
		.sign_ext (1'b1),
		.shift    (2'h0),
		.res      (disp_x)
	);

	// index: zero-extend part of the register and scale
	eau_ext u_index (
		.src      (index_reg),
		.size     (op_size),
		.sign_ext (1'b0),
		.shift    (shift_of(op_size)),
		.res      (idx_scaled)
	);

	// immediate zero-extended to the operand size
	eau_ext u_imm (
		.src      (disp),
		.size     (op_size),
		.sign_ext (1'b0),
		.shift    (2'h0),
		.res      (imm_x)
	);

	// pc relative displacement of 8 or 16 bits
	eau_ext u_pcd (
		.src      (disp),
		.size     (disp_long ? EAU_SZ_WORD : EAU_SZ_BYTE),
		.sign_ext (1'b1),
		.shift    (2'h0),
		.res      (pc_disp)
	);

	// ==========================================
	// address calculation
	logic [31:0] ea_c, imm_c, wbv_c, step;
	logic        wb_c, err_c, is_branch;

	always_comb begin
		step      = step_of(op_size);
		ea_c      = EAU_ZERO;
		imm_c     = EAU_ZERO;
		wb_c      = 1'b0;
		wbv_c     = base;
		err_c     = 1'b0;
		is_branch = 1'b0;
		case (ea_mode)
			EAU_MODE_IND: ea_c = base;
			EAU_MODE_DISP: ea_c = base + disp_x;
			EAU_MODE_DISP2: begin
				// short form: 1..3 times the step
				err_c = (disp_short == 2'h0);
				ea_c  = base + ({30'h0000_0000, disp_short}
					<< shift_of(op_size));
			end
			EAU_MODE_INDEX: ea_c = idx_scaled + disp_x;
			EAU_MODE_POSTINC: begin
				ea_c  = base;
				wb_c  = 1'b1;
				wbv_c = base + step;
			end
			EAU_MODE_PREDEC: begin
				ea_c  = base - step;
				wb_c  = 1'b1;
				wbv_c = base - step;
			end
			EAU_MODE_PREINC: begin
				ea_c  = base + step;
				wb_c  = 1'b1;
				wbv_c = base + step;
			end
			EAU_MODE_POSTDEC: begin
				ea_c  = base;
				wb_c  = 1'b1;
				wbv_c = base - step;
			end
			EAU_MODE_ABS8:
				ea_c = {short_address_base[31:8], disp[7:0]};
			EAU_MODE_ABS16: ea_c = sx16(disp);
			EAU_MODE_ABS24: ea_c = disp & EAU_MASK24;
			EAU_MODE_ABS32: ea_c = disp;
			EAU_MODE_IMM: imm_c = imm_x;
			EAU_MODE_IMPL: begin
				case (impl_kind)
					EAU_IMPL_BITNUM:
						imm_c = {29'h0000_0000,
							opcode[EAU_BITNUM_LSB +: 3]};
					EAU_IMPL_FIELD:
						imm_c = {24'h00_0000,
							opcode[EAU_FIELD_LSB +: 8]};
					EAU_IMPL_TRAP:
						imm_c = {30'h0000_0000,
							opcode[EAU_TRAP_LSB +: 2]};
					default: err_c = 1'b1;
				endcase
			end
			EAU_MODE_PCREL: begin
				ea_c      = next_pc + pc_disp;
				is_branch = 1'b1;
			end
			EAU_MODE_BRIND: begin
				ea_c      = base;
				is_branch = 1'b1;
			end
			default: err_c = 1'b1;
		endcase
		// trim by cpu operating mode
		if (is_branch && cpu_mode != EAU_CPU_MAXIMUM &&
			cpu_mode != EAU_CPU_NORMAL) begin
			ea_c = ea_c & EAU_MASK24;
		end else if (!is_branch && cpu_mode == EAU_CPU_MIDDLE
			&& ea_mode != EAU_MODE_ABS24) begin
			ea_c = sx16(ea_c);
		end
	end

	// ==========================================
	// output registers
	logic        ea_valid_nxt, wb_en_nxt, err_nxt;
	logic [31:0] ea_addr_nxt, imm_nxt, wb_value_nxt, wdata_nxt;
	logic [2:0]  wb_reg_nxt;

	// next values for results and the forwarding path
	always_comb begin
		ea_valid_nxt = req_valid;
		ea_addr_nxt  = req_valid ? ea_c : ea_addr;
		imm_nxt      = req_valid ? imm_c : imm_value;
		wb_en_nxt    = req_valid & wb_c;
		wb_reg_nxt   = req_valid ? reg_sel : wb_reg;
		wb_value_nxt = req_valid ? wbv_c : wb_value;
		wdata_nxt    = req_valid ? wbv_c : reg_wdata;
		err_nxt      = req_valid & err_c;
		fwd_ok_nxt   = req_valid ? wb_c : fwd_ok_r;
		fwd_reg_nxt  = req_valid ? reg_sel : fwd_reg_r;
		fwd_val_nxt  = req_valid ? wbv_c : fwd_val_r;
	end

	// register the results
	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			ea_valid  <= 1'b0;
			ea_addr   <= EAU_ZERO;
			imm_value <= EAU_ZERO;
			wb_en     <= 1'b0;
			wb_reg    <= 3'h0;
			wb_value  <= EAU_ZERO;
			reg_wdata <= EAU_ZERO;
			ea_error  <= 1'b0;
			fwd_ok_r  <= 1'b0;
			fwd_reg_r <= 3'h0;
			fwd_val_r <= EAU_ZERO;
		end else begin
			ea_valid  <= ea_valid_nxt;
			ea_addr   <= ea_addr_nxt;
			imm_value <= imm_nxt;
			wb_en     <= wb_en_nxt;
			wb_reg    <= wb_reg_nxt;
			wb_value  <= wb_value_nxt;
			reg_wdata <= wdata_nxt;
			ea_error  <= err_nxt;
			fwd_ok_r  <= fwd_ok_nxt;
			fwd_reg_r <= fwd_reg_nxt;
			fwd_val_r <= fwd_val_nxt;
		end
	end

	// ==========================================
	// checks
	chk_postinc_step: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_POSTINC && !second_ea
		&& cpu_mode != EAU_CPU_MIDDLE
		|=> wb_value == $past(address_register_32) + $past(step)
		&& ea_addr == $past(address_register_32))
		else $error("post-increment result wrong");
	chk_predec_addr: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_PREDEC && !second_ea
		&& cpu_mode != EAU_CPU_MIDDLE
		|=> ea_addr == wb_value && wb_en)
		else $error("pre-decrement address differs");
	chk_preinc_addr: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_PREINC && !second_ea
		&& cpu_mode != EAU_CPU_MIDDLE
		|=> ea_addr == $past(address_register_32) + $past(step))
		else $error("pre-increment address wrong");
	chk_postdec_val: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_POSTDEC && !second_ea
		|=> wb_value == $past(address_register_32) - $past(step))
		else $error("post-decrement write-back wrong");
	chk_step_long: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_POSTINC && !second_ea
		&& op_size == EAU_SZ_LONG
		|=> wb_value - ea_addr == EAU_STEP_LONG)
		else $error("longword step not four");
	chk_abs24_top: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_ABS24
		|=> ea_addr[31:24] == 8'h00)
		else $error("24-bit address upper byte set");
	chk_short_zero: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_DISP2 && disp_short == 2'h0
		|=> ea_error)
		else $error("short displacement zero accepted");
	chk_branch_adv: assert property (@(posedge clk) disable iff (!rst_s2_r)
		req_valid && ea_mode == EAU_MODE_PCREL
		&& cpu_mode == EAU_CPU_ADVANCED
		|=> ea_addr[31:24] == 8'h00 && ea_valid)
		else $error("advanced branch target upper byte set");
	chk_wdata_upd: assert property (@(posedge clk) disable iff (!rst_s2_r)
		ea_valid && wb_en |-> reg_wdata == wb_value)
		else $error("write data not updated value");

endmodule

// ### common/eau_pkg.sv
// package: effective address unit encodings and constants
package eau_pkg;

	// ==========================================
	// addressing modes
	typedef enum logic [3:0] {
		EAU_MODE_IND      = 4'h0,
		EAU_MODE_DISP     = 4'h1,
		EAU_MODE_DISP2    = 4'h2,
		EAU_MODE_INDEX    = 4'h3,
		EAU_MODE_POSTINC  = 4'h4,
		EAU_MODE_PREDEC   = 4'h5,
		EAU_MODE_PREINC   = 4'h6,
		EAU_MODE_POSTDEC  = 4'h7,
		EAU_MODE_ABS8     = 4'h8,
		EAU_MODE_ABS16    = 4'h9,
		EAU_MODE_ABS24    = 4'ha,
		EAU_MODE_ABS32    = 4'hb,
		EAU_MODE_IMM      = 4'hc,
		EAU_MODE_PCREL    = 4'hd,
		EAU_MODE_IMPL     = 4'he,
		EAU_MODE_BRIND    = 4'hf
	} eau_mode_type;

	// ==========================================
	// operand sizes
	typedef enum logic [1:0] {
		EAU_SZ_BYTE = 2'h0,
		EAU_SZ_WORD = 2'h1,
		EAU_SZ_LONG = 2'h2
	} eau_size_type;

	// ==========================================
	// cpu operating modes
	typedef enum logic [1:0] {
		EAU_CPU_NORMAL   = 2'h0,
		EAU_CPU_MIDDLE   = 2'h1,
		EAU_CPU_ADVANCED = 2'h2,
		EAU_CPU_MAXIMUM  = 2'h3
	} eau_cpu_type;

	// ==========================================
	// implicit immediate kinds
	typedef enum logic [1:0] {
		EAU_IMPL_BITNUM = 2'h0,
		EAU_IMPL_FIELD  = 2'h1,
		EAU_IMPL_TRAP   = 2'h2
	} eau_impl_type;

	// ==========================================
	// step sizes and field positions
	localparam logic [31:0] EAU_STEP_BYTE  = 32'h0000_0001;
	localparam logic [31:0] EAU_STEP_WORD  = 32'h0000_0002;
	localparam logic [31:0] EAU_STEP_LONG  = 32'h0000_0004;
	localparam int          EAU_SHIFT_WORD = 1;
	localparam int          EAU_SHIFT_LONG = 2;
	localparam int          EAU_BITNUM_LSB = 4;
	localparam int          EAU_FIELD_LSB  = 0;
	localparam int          EAU_TRAP_LSB   = 4;
	localparam logic [31:0] EAU_MASK24     = 32'h00ff_ffff;
	localparam logic [31:0] EAU_ZERO       = 32'h0000_0000;

endpackage

// ### design/eau_ext.sv
// file: extension and scaling helper for the address unit
`timescale 1ns/1ns

// ==========================================
// zero or sign extension of a sized field, then scale
module eau_ext
	import eau_pkg::*;
(
	// source field and controls
	input  wire logic [31:0] src,
	input  wire logic [1:0]  size,
	input  wire logic        sign_ext,
	input  wire logic [1:0]  shift,
	// result
	output logic      [31:0] res
);

	logic [31:0] ext;

	// extend the byte, word or longword part of the source
	always_comb begin
		case (size)
			EAU_SZ_BYTE: ext = {{24{sign_ext & src[7]}}, src[7:0]};
			EAU_SZ_WORD: ext = {{16{sign_ext & src[15]}}, src[15:0]};
			default:     ext = src;
		endcase
		res = ext << shift;
	end

endmodule

// ### tb/eau_partner.sv
// decoder register file model feeding the address unit
`timescale 1ns/1ns

// ==========================================
// register file, updated by the unit's write-back
module eau_partner
	import eau_pkg::*;
(
	// clock
	input  wire logic        clk,
	// register read
	input  wire logic [2:0]  reg_sel,
	output logic      [31:0] address_register_32,
	// write-back from the unit
	input  wire logic        wb_en,
	input  wire logic [2:0]  wb_reg,
	input  wire logic [31:0] wb_value
);
	logic [31:0] regs [8];

	// preload a register from the bench
	task automatic set_reg(input logic [2:0] r, input logic [31:0] v);
		regs[r] = v;
	endtask

	// read port follows the selector
	assign address_register_32 = regs[reg_sel];

	// write-back lands at the edge after the one that flags it
	always @(posedge clk) begin
		if (wb_en === 1'b1) begin
			regs[wb_reg] <= wb_value;
		end
	end
endmodule

// ### tb/tb.sv
// self-checking bench for the effective address unit
`timescale 1ns/1ns

// ==========================================
// bench top
module tb
	import eau_pkg::*;
;
	localparam logic [31:0] BASE = 32'h0000_1000;
	logic        clk, rstn, req_valid, disp_long, second_ea, se_v;
	logic        ea_valid, wb_en, ea_error;
	logic [3:0]  ea_mode;
	logic [1:0]  op_size, cpu_mode, disp_short, impl_kind, ds_v, ik_v;
	logic [2:0]  reg_sel, wb_reg, rs_v;
	logic [15:0] opcode, op_v;
	logic [31:0] index_reg, disp, next_pc, short_address_base;
	logic [31:0] address_register_32, ea_addr, imm_value, wb_value;
	logic [31:0] reg_wdata, ix_v, pc_v, sab_v;
	int          fail_count, checks_done;

	eau_core dut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
		.ea_mode(ea_mode), .op_size(op_size), .cpu_mode(cpu_mode),
		.reg_sel(reg_sel), .address_register_32(address_register_32),
		.index_reg(index_reg), .disp(disp), .disp_long(disp_long),
		.disp_short(disp_short), .next_pc(next_pc), .opcode(opcode),
		.impl_kind(impl_kind), .second_ea(second_ea),
		.short_address_base(short_address_base), .ea_valid(ea_valid),
		.ea_addr(ea_addr), .imm_value(imm_value), .wb_en(wb_en),
		.wb_reg(wb_reg), .wb_value(wb_value), .reg_wdata(reg_wdata),
		.ea_error(ea_error));
	eau_partner ptr (.clk(clk), .reg_sel(reg_sel),
		.address_register_32(address_register_32), .wb_en(wb_en),
		.wb_reg(wb_reg), .wb_value(wb_value));

	// clock at 125 MHz
	always #4 clk = ~clk;

	// ==========================================
	// compare and closing tasks
	task automatic cmp32(input string n, input logic [31:0] e, s);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp1(input string n, input logic e, s);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// one request at an edge; answer looked at one cycle later
	task automatic rq(input logic [3:0] m, input logic [1:0] sz, cpu,
			input logic [31:0] d, input logic dl);
		@(posedge clk);
		req_valid <= 1'b1;
		ea_mode <= m;
		op_size <= sz;
		cpu_mode <= cpu;
		disp <= d;
		disp_long <= dl;
		reg_sel <= rs_v;
		index_reg <= ix_v;
		next_pc <= pc_v;
		opcode <= op_v;
		impl_kind <= ik_v;
		second_ea <= se_v;
		disp_short <= ds_v;
		short_address_base <= sab_v;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		cmp1("ea_valid", 1'b1, ea_valid);
	endtask

	// ==========================================
	// scenarios
	task automatic t_disp();
		rs_v = 3'h1;
		ptr.set_reg(3'h1, 32'h0001_0000);
		rq(EAU_MODE_DISP, 2'h1, 2'h0, 32'h0000_8000, 1'b0);
		cmp32("disp16", 32'h0000_8000, ea_addr);
		rq(EAU_MODE_DISP, 2'h1, 2'h0, 32'h8000_0000, 1'b1);
		cmp32("disp32", 32'h8001_0000, ea_addr);
		ptr.set_reg(3'h1, 32'h0000_7ff0);
		rq(EAU_MODE_DISP, 2'h1, 2'h1, 32'h0000_0020, 1'b0);
		cmp32("middle", 32'hffff_8010, ea_addr);
		ptr.set_reg(3'h1, 32'hab12_3456);
		rq(EAU_MODE_BRIND, 2'h2, 2'h2, 32'h0, 1'b0);
		cmp32("brind", 32'h0012_3456, ea_addr);
		for (int s = 0; s < 3; s++) begin
			for (int c = 0; c < 4; c++) begin
				ptr.set_reg(3'h1, BASE);
				ds_v = c[1:0];
				rq(EAU_MODE_DISP2, s[1:0], 2'h0, 32'h0, 1'b0);
				cmp32("short", BASE + (c << s), ea_addr);
				cmp1("short_err", c == 0, ea_error);
			end
		end
		$display("t_disp done");
	endtask

	task automatic t_index();
		logic [31:0] mk;
		ix_v = 32'h1234_5687;
		for (int s = 0; s < 3; s++) begin
			mk = (s == 0) ? 32'h0000_00ff : (s == 1) ? 32'h0000_ffff : '1;
			rq(EAU_MODE_INDEX, s[1:0], 2'h0, 32'h0000_fff0, 1'b0);
			cmp32("index", ((ix_v & mk) << s) - 32'h10, ea_addr);
		end
		rq(EAU_MODE_INDEX, 2'h0, 2'h0, 32'h0001_0000, 1'b1);
		cmp32("index32", 32'h0001_0087, ea_addr);
		$display("t_index done");
	endtask

	task automatic t_auto();
		logic [31:0] st, nv;
		rs_v = 3'h2;
		for (int m = 4; m < 8; m++) begin
			for (int s = 0; s < 3; s++) begin
				st = 32'h0000_0001 << s;
				nv = (m == 4 || m == 6) ? BASE + st : BASE - st;
				// let the previous write-back land before preloading
				@(posedge clk);
				@(negedge clk);
				ptr.set_reg(3'h2, BASE);
				rq(m[3:0], s[1:0], 2'h0, 32'h0, 1'b0);
				cmp32("auto_ea", (m == 5 || m == 6) ? nv : BASE,
					ea_addr);
				cmp1("wb_en", 1'b1, wb_en);
				cmp32("wb_reg", 32'h2, {29'h0, wb_reg});
				cmp32("wb_value", nv, wb_value);
				cmp32("wdata", nv, reg_wdata);
			end
		end
		@(posedge clk);
		@(negedge clk);
		ptr.set_reg(3'h2, BASE);
		rq(EAU_MODE_POSTINC, 2'h0, 2'h0, 32'h0, 1'b0);
		// stale register file value: only forwarding gives the update
		@(posedge clk);
		@(negedge clk);
		ptr.set_reg(3'h2, BASE);
		se_v = 1'b1;
		rq(EAU_MODE_POSTINC, 2'h0, 2'h0, 32'h0, 1'b0);
		se_v = 1'b0;
		cmp32("second_ea", BASE + 32'h1, ea_addr);
		cmp32("second_wb", BASE + 32'h2, wb_value);
		$display("t_auto done");
	endtask

	task automatic t_abs();
		sab_v = 32'h1234_5600;
		rq(EAU_MODE_ABS8, 2'h0, 2'h0, 32'hffff_ff9a, 1'b0);
		cmp32("abs8", 32'h1234_569a, ea_addr);
		rq(EAU_MODE_ABS16, 2'h0, 2'h0, 32'h0000_8001, 1'b0);
		cmp32("abs16", 32'hffff_8001, ea_addr);
		rq(EAU_MODE_ABS24, 2'h0, 2'h0, 32'hffab_cdef, 1'b0);
		cmp32("abs24", 32'h00ab_cdef, ea_addr);
		rq(EAU_MODE_ABS32, 2'h0, 2'h0, 32'h89ab_cdef, 1'b0);
		cmp32("abs32", 32'h89ab_cdef, ea_addr);
		cmp1("no_wb", 1'b0, wb_en);
		rq(EAU_MODE_ABS24, 2'h0, 2'h1, 32'hffab_cdef, 1'b0);
		cmp32("abs24_mid", 32'h00ab_cdef, ea_addr);
		$display("t_abs done");
	endtask

	task automatic t_imm();
		logic [31:0] ex [4];
		ex = '{32'h0000_00ab, 32'h0000_ffab, 32'hffff_ffab, 32'h0};
		for (int s = 0; s < 3; s++) begin
			rq(EAU_MODE_IMM, s[1:0], 2'h0, 32'hffff_ffab, 1'b0);
			cmp32("imm", ex[s], imm_value);
		end
		ex = '{32'h3, 32'hb7, 32'h3, 32'h0};
		op_v = 16'ha5b7;
		for (int k = 0; k < 4; k++) begin
			ik_v = k[1:0];
			rq(EAU_MODE_IMPL, 2'h0, 2'h0, 32'h0, 1'b0);
			if (k < 3) cmp32("impl", ex[k], imm_value);
			cmp1("impl_err", k == 3, ea_error);
		end
		$display("t_imm done");
	endtask

	task automatic t_pcrel();
		pc_v = BASE;
		rq(EAU_MODE_PCREL, 2'h0, 2'h0, 32'h0000_0080, 1'b0);
		cmp32("pc8", 32'h0000_0f80, ea_addr);
		rq(EAU_MODE_PCREL, 2'h0, 2'h0, 32'h0000_7fff, 1'b1);
		cmp32("pc16", 32'h0000_8fff, ea_addr);
		pc_v = 32'hff00_0010;
		rq(EAU_MODE_PCREL, 2'h0, 2'h2, 32'h0000_0010, 1'b0);
		cmp32("pc_adv", 32'h0000_0020, ea_addr);
		$display("t_pcrel done");
	endtask

	// ==========================================
	// main sequence
	initial begin
		{clk, rstn, req_valid, disp_long, second_ea, se_v} = '0;
		{ea_mode, op_size, cpu_mode, disp_short, impl_kind} = '0;
		{ds_v, ik_v, reg_sel, rs_v, opcode, op_v} = '0;
		{index_reg, disp, next_pc, short_address_base} = '0;
		{ix_v, pc_v, sab_v, fail_count, checks_done} = '0;
		repeat (6) @(posedge clk);
		#1;
		cmp1("rst_valid", 1'b0, ea_valid);
		cmp32("rst_addr", 32'h0, ea_addr);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		t_disp();
		t_index();
		t_auto();
		t_abs();
		t_imm();
		t_pcrel();
		report_and_stop();
	end

	// watchdog well beyond the roughly 120 cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule
